// [rtl/eewc_ctrl.sv]
// eeprom write control register, write timer and interrupt logic
`timescale 1ns/10ps
module eewc_ctrl
  import eewc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_8bit_timer,
  input  wire logic        ee_wr_req,
  output logic             ee_wr_start,
  output logic             ee_rd_allow,
  output logic             ee_wr_allow,
  output logic             ee_standby,
  output logic             write_in_progress_flag,
  output logic             write_done_irq,
  output logic             irq
);
  import eewc_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]            ctrl_q, ctrl_d;
  logic [EEWC_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic                  dp_wr_q, dp_wr_d;
  logic [31:0]           dp_addr_q, dp_addr_d;
  logic [31:0]           rdata_d;
  eewc_state_e           state_q, state_d;
  logic [7:0]            cnt_q, cnt_d;
  logic                  tick;
  logic                  start_d, done_d, rd_ok_d, wr_ok_d, irq_d;

  // register index match, used for both read and write decoding
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // ------------------------------------------------------------
  // count clock
  // ------------------------------------------------------------
  // one tick pulse per count clock period, from the divider or the timer
  eewc_tick u_tick (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .sel            (ctrl_q[EEWC_SEL_LSB +: EEWC_SEL_W]),
    .ext_8bit_timer (ext_8bit_timer),
    .tick_q         (tick)
  );

  // ------------------------------------------------------------
  // ahb-lite slave: zero wait, always okay
  // ------------------------------------------------------------
  // read data is muxed in the address phase so hrdata is a flop
  always_comb begin
    logic addr_ok;
    addr_ok   = hsel & hready & (htrans == EEWC_HTRANS_NSEQ);
    dp_wr_d   = addr_ok & hwrite;
    dp_addr_d = haddr;
    rdata_d   = '0;  // unmapped reads return zero
    if (addr_ok & ~hwrite) begin
      if (hit(haddr, EEWC_CTRL_ADDR)) begin
        rdata_d[7:0] = ctrl_q;
        // bit 1 shows the live busy state, never a stored value
        rdata_d[EEWC_WIP_BIT] = (state_q == EEWC_ST_WRITE);
      end else if (hit(haddr, EEWC_STAT_ADDR)) begin
        rdata_d[EEWC_IRQ_W-1:0] = stat_q;
      end else if (hit(haddr, EEWC_MASK_ADDR)) begin
        rdata_d[EEWC_IRQ_W-1:0] = mask_q;
      end
    end
  end

  // ------------------------------------------------------------
  // register file and write sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] wv;
    wv      = hwdata[7:0];
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    state_d = state_q;
    cnt_d   = cnt_q;
    start_d = 1'b0;
    done_d  = 1'b0;
    if (dp_wr_q && hit(dp_addr_q, EEWC_CTRL_ADDR)) begin
      ctrl_d = (ctrl_q & ~EEWC_WR_MASK) | (wv & EEWC_WR_MASK);
      // write enable cannot stand without read enable
      if (!wv[EEWC_RE_BIT]) begin
        ctrl_d[EEWC_WE_BIT] = 1'b0;
      end
    end
    if (dp_wr_q && hit(dp_addr_q, EEWC_MASK_ADDR)) begin
      mask_d = hwdata[EEWC_IRQ_W-1:0];
    end
    // --------------------------------------------------------
    // write sequencer
    // --------------------------------------------------------
    // the count restarts only from idle, so busy requests cannot stretch it
    unique case (state_q)
      EEWC_ST_IDLE: begin
        // write only with both enables set
        if (ee_wr_req && ctrl_q[EEWC_RE_BIT] && ctrl_q[EEWC_WE_BIT]) begin
          state_d = EEWC_ST_WRITE;
          cnt_d   = '0;
          start_d = 1'b1;
        end
      end
      EEWC_ST_WRITE: begin
        // requests here are dropped and do not restart the count
        if (tick) begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == EEWC_WR_TICKS - 8'h01) begin
            state_d = EEWC_ST_IDLE;
            done_d  = 1'b1;
          end
        end
      end
      default: begin
        state_d = EEWC_ST_IDLE;
      end
    endcase
    // --------------------------------------------------------
    // status and interrupt
    // --------------------------------------------------------
    // w1c, but a completion in the same cycle wins
    if (dp_wr_q && hit(dp_addr_q, EEWC_STAT_ADDR)) begin
      stat_d = stat_q & ~hwdata[EEWC_IRQ_W-1:0];
    end
    if (done_d) begin
      stat_d[EEWC_DONE_BIT] = 1'b1;
    end
    rd_ok_d = ctrl_d[EEWC_RE_BIT] & (state_d == EEWC_ST_IDLE);
    wr_ok_d = rd_ok_d & ctrl_d[EEWC_WE_BIT];
    irq_d   = |(stat_d & mask_d);
  end

  // ------------------------------------------------------------
  // bus side flops
  // ------------------------------------------------------------
  // response is constant, but kept in flops so every output is registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= EEWC_HRESP_OKAY;
    end else begin
      dp_wr_q   <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= EEWC_HRESP_OKAY;
    end
  end

  // ------------------------------------------------------------
  // register and sequencer flops
  // ------------------------------------------------------------
  // a reset in mid write drops the count; the cell value is then undefined
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= EEWC_CTRL_RESET;
      stat_q  <= '0;
      mask_q  <= '0;
      state_q <= EEWC_ST_IDLE;
      cnt_q   <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // device side outputs
  // ------------------------------------------------------------
  // outputs follow the next state, so the allows drop in the start cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ee_wr_start            <= 1'b0;
      ee_rd_allow            <= 1'b0;
      ee_wr_allow            <= 1'b0;
      ee_standby             <= 1'b1;
      write_in_progress_flag <= 1'b0;
      write_done_irq         <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      ee_wr_start            <= start_d;
      ee_rd_allow            <= rd_ok_d;
      ee_wr_allow            <= wr_ok_d;
      ee_standby             <= ~ctrl_d[EEWC_RE_BIT];
      write_in_progress_flag <= (state_d == EEWC_ST_WRITE);
      write_done_irq         <= done_d;
      irq                    <= irq_d;
    end
  end
endmodule

// [rtl/eewc_pkg.sv]
// constants shared by the eeprom write control block
package eewc_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [31:0] EEWC_CTRL_ADDR   = 32'h0000FFD8;
  localparam logic [31:0] EEWC_STAT_ADDR   = 32'h0000FFE0;
  localparam logic [31:0] EEWC_MASK_ADDR   = 32'h0000FFE4;
  localparam logic [7:0]  EEWC_CTRL_RESET  = 8'h08;
  localparam logic [7:0]  EEWC_WR_MASK     = 8'hFD;  // all but the status bit
  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int EEWC_WE_BIT   = 0;
  localparam int EEWC_WIP_BIT  = 1;
  localparam int EEWC_RE_BIT   = 2;
  localparam int EEWC_SEL_LSB  = 4;
  localparam int EEWC_SEL_W    = 3;
  localparam int EEWC_IRQ_W    = 1;
  localparam int EEWC_DONE_BIT = 0;
  // ------------------------------------------------------------
  // count clock select codes and timing
  // ------------------------------------------------------------
  localparam logic [2:0] EEWC_SEL_TIMER  = 3'h6;
  localparam logic [2:0] EEWC_SEL_BAD    = 3'h7;
  localparam int         EEWC_DIV_MIN_LOG = 3;      // code 000 divides by 2^3
  localparam int         EEWC_DIV_W      = 8;      // largest tap is 2^8
  localparam logic [7:0] EEWC_WR_TICKS   = 8'h91;  // 145 count clock periods
  localparam logic [1:0] EEWC_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0] EEWC_HRESP_OKAY = 2'h0;
  // ------------------------------------------------------------
  // write sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EEWC_ST_IDLE  = 2'b01,
    EEWC_ST_WRITE = 2'b10
  } eewc_state_e;
endpackage

// [rtl/eewc_tick.sv]
// count clock tick generator for the eeprom write timer
`timescale 1ns/10ps
module eewc_tick
  import eewc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic [EEWC_SEL_W-1:0] sel,
  input  wire logic                  ext_8bit_timer,
  output logic                       tick_q
);
  logic [EEWC_DIV_W-1:0] div_q, div_d;
  logic                  sync1_q, sync2_q, prev_q;
  logic                  tick_d;

  // ------------------------------------------------------------
  // divider taps and timer edge
  // ------------------------------------------------------------
  // tick when the low (code+3) divider bits are all ones
  always_comb begin
    logic [EEWC_DIV_W-1:0] m;
    m      = '0;
    div_d  = div_q + 8'h01;
    tick_d = 1'b0;
    if (sel == EEWC_SEL_TIMER) begin
      tick_d = sync2_q & ~prev_q;
    end else if (sel != EEWC_SEL_BAD) begin
      m      = ~(8'hFF << (32'(sel) + EEWC_DIV_MIN_LOG));
      tick_d = ((div_q & m) == m);
    end
  end

  // sync1 feeds only sync2; edge detect looks at sync2 and its delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q   <= '0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      tick_q  <= 1'b0;
    end else begin
      div_q   <= div_d;
      sync1_q <= ext_8bit_timer;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      tick_q  <= tick_d;
    end
  end
endmodule

// [test/eewc_ctrl_sva.sv]
// assertion checker for the eeprom write control block
`timescale 1ns/10ps
module eewc_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic [1:0] hresp,
  input wire logic       ee_wr_req,
  input wire logic       ee_wr_start,
  input wire logic       ee_rd_allow,
  input wire logic       ee_wr_allow,
  input wire logic       ee_standby,
  input wire logic       write_in_progress_flag,
  input wire logic       write_done_irq,
  input wire logic       irq
);
  // ----------------------------------------
  // properties, all on the bus clock
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_zero_wait: assert property (hreadyout && hresp == 2'h0)
    else $error("bus not ready or bad response");
  a_start_from_req: assert property (ee_wr_start |-> $past(ee_wr_req))
    else $error("write start without request");
  a_start_sets_flag: assert property (ee_wr_start |-> write_in_progress_flag)
    else $error("start without busy flag");
  a_busy_ignores_req: assert property (write_in_progress_flag && ee_wr_req |=> !ee_wr_start)
    else $error("request accepted while busy");
  a_busy_no_access: assert property (write_in_progress_flag |-> !ee_rd_allow && !ee_wr_allow)
    else $error("access allowed while busy");
  a_write_needs_read: assert property (ee_wr_allow |-> ee_rd_allow)
    else $error("write allowed without read");
  a_standby_no_access: assert property (ee_standby |-> !ee_rd_allow && !ee_wr_allow)
    else $error("access allowed in standby");
  a_done_ends_busy: assert property (write_done_irq |-> $past(write_in_progress_flag) && !write_in_progress_flag)
    else $error("done pulse outside write end");
  a_flag_fall_done: assert property ($fell(write_in_progress_flag) |-> write_done_irq)
    else $error("busy fell without done pulse");
  a_flag_min_len: assert property ($rose(write_in_progress_flag) |-> write_in_progress_flag[*8])
    else $error("write shorter than one tick");
  // main scenarios reached
  c_done: cover property (write_done_irq);
  c_busy_req: cover property (ee_wr_req && write_in_progress_flag);
  c_irq: cover property (irq);
endmodule
bind eewc_ctrl eewc_sva eewc_sva_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .ee_wr_req(ee_wr_req), .ee_wr_start(ee_wr_start), .ee_rd_allow(ee_rd_allow),
  .ee_wr_allow(ee_wr_allow), .ee_standby(ee_standby), .irq(irq),
  .write_in_progress_flag(write_in_progress_flag), .write_done_irq(write_done_irq));

// [test/test_eewc_ctrl.sv]
// self-checking bench for the eeprom write control block
`timescale 1ns/10ps
module test_eewc_ctrl;
  import eewc_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_8bit_timer = 0, ee_wr_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, hresp;
  logic        hreadyout, ee_wr_start, ee_rd_allow, ee_wr_allow, ee_standby;
  logic        write_in_progress_flag, write_done_irq, irq;
  int          fails = 0, checked = 0, cyc = 0, t0;
  // ----------------------------------------
  // clock, free cycle count, timer output of period 16
  // ----------------------------------------
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ext_8bit_timer <= cyc[3];
  end
  eewc_ctrl eewc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_8bit_timer(ext_8bit_timer),
    .ee_wr_req(ee_wr_req), .ee_wr_start(ee_wr_start), .ee_rd_allow(ee_rd_allow),
    .ee_wr_allow(ee_wr_allow), .ee_standby(ee_standby), .irq(irq),
    .write_in_progress_flag(write_in_progress_flag), .write_done_irq(write_done_irq));
  // ----------------------------------------
  // report, compare and bus tasks
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for hready at the next edges
  task rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin fails++; end_sim; end
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= EEWC_HTRANS_NSEQ;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(n, rd, e);
  endtask
  task pulse;
    ee_wr_req <= 1;
    @(posedge hclk);
    ee_wr_req <= 0;
  endtask
  // one write with count select c, expected tick period p in cycles
  task run(input logic [2:0] c, input int p);
    int n;
    bus(1, EEWC_CTRL_ADDR, {25'h0, c, 4'hD});
    pulse;
    t0 = cyc;
    rchk("ctrl_busy", EEWC_CTRL_ADDR, {25'h0, c, 4'hF});
    repeat (p) @(posedge hclk);  // a tick has landed, so a restart would show
    pulse; // busy request must not restart the count
    n = 0;
    while (write_done_irq !== 1'b1) begin
      if (++n > 40000) begin fails++; end_sim; end
      @(posedge hclk);
    end
    chk("duration", 32'(cyc - t0 >= 144 * p && cyc - t0 <= 145 * p + 1), 1);
    rchk("status_set", EEWC_STAT_ADDR, 1);
    chk("irq_up", irq, 1);
    bus(1, EEWC_STAT_ADDR, 1);
    rchk("status_clr", EEWC_STAT_ADDR, 0);
    chk("irq_down", irq, 0);
    $display("write test code %0d done", c);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    rchk("ctrl_reset", EEWC_CTRL_ADDR, 32'h08);
    bus(1, EEWC_CTRL_ADDR, 32'h0E);
    rchk("flag_ro", EEWC_CTRL_ADDR, 32'h0C);
    chk("rd_allow", ee_rd_allow, 1);
    bus(1, EEWC_CTRL_ADDR, 32'h0D);
    rchk("both_en", EEWC_CTRL_ADDR, 32'h0D);
    chk("wr_allow", ee_wr_allow, 1);
    bus(1, EEWC_CTRL_ADDR, 32'h09);
    rchk("re_clear", EEWC_CTRL_ADDR, 32'h08);
    chk("standby", ee_standby, 1);
    bus(1, EEWC_CTRL_ADDR, 32'h0C);
    pulse; // write enable low, so this is refused
    repeat (3) @(posedge hclk);
    chk("no_write", write_in_progress_flag, 0);
    bus(1, EEWC_MASK_ADDR, 1);
    rchk("mask", EEWC_MASK_ADDR, 1);
    rchk("unmapped", 32'h0000FFDC, 0);
    $display("register test done");
    // every divider code runs, up to 256 cycles a tick; the write window is software's
    for (int k = 0; k < 6; k++) run(k[2:0], 8 << k);
    run(EEWC_SEL_TIMER, 16);
    bus(1, EEWC_CTRL_ADDR, 32'h7D);
    pulse; // prohibited code: no ticks, write never ends
    repeat (300) @(posedge hclk);
    chk("stuck_busy", write_in_progress_flag, 1);
    hresetn <= 0;
    @(posedge hclk);
    hresetn <= 1;
    rchk("ctrl_rereset", EEWC_CTRL_ADDR, 32'h08);
    $display("reset test done");
    end_sim;
  end
endmodule
